// ==== pkg/i2mt_pkg.sv ====
// Constants and types for the two-wire master byte transmitter.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
package i2mt_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_TX_BUFFER = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CONTROL_TWO = 8'h08;
    localparam logic [7:0] OFF_BAUD = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h18;
    // Status register fields
    localparam int BIT_BUFFER_FULL = 0;
    localparam int BIT_WRITE_COLLISION = 1;
    localparam int BIT_SERIAL_IRQ = 2;
    // Second control register fields
    localparam int BIT_START_REQ = 0;
    localparam int BIT_RESTART_REQ = 1;
    localparam int BIT_STOP_REQ = 2;
    localparam int BIT_ACK_STATUS = 6;
    // Interrupt status fields
    localparam int IRQ_BYTE_DONE = 0;
    localparam int IRQ_COND_DONE = 1;
    localparam int IRQ_COLLISION = 2;
    localparam int IRQ_WIDTH = 3;
    // Reset values, bus response codes and bits per byte
    localparam logic [7:0] BAUD_RESET = 8'h9F;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_START_A, ST_START_B, ST_RESTART_A, ST_RESTART_B,
        ST_BIT_LOW, ST_BIT_HIGH, ST_ACK_LOW, ST_ACK_HIGH,
        ST_STOP_A, ST_STOP_B, ST_STOP_C
    } i2mt_state_type;
endpackage

// ==== src/i2mt_top.sv ====
// Two-wire bus master, transmit path, with AXI4-Lite registers.
// Assumes synchronous pin inputs and an external open-drain pad per line.
//
// Contract
// - Buffer write shifts address and direction bit out
// - Release data line after eighth falling edge
// - Sample data line at ninth falling edge
// - Store sampled acknowledge in control register two
// - Set serial interrupt flag after ninth edge
// - Clear buffer full after ninth edge
// - Halt baud generator, clock low, data released
// - Buffer write sets buffer full flag
// - Buffer full clears when eight bits left; the code clears it after the ninth edge
// - Write during shift sets collision, discarded
// - Acknowledge flag reads 0 acked, 1 not
// - Stop or restart raises interrupt when done
module i2mt_top (
    // System
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Two-wire bus, open drain: enable high pulls the line low
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Interrupt
    output logic irq
);

    // All state of the block in one record
    typedef struct packed {
        logic aw_seen;
        logic [7:0] aw_addr;
        logic w_seen;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] tx_buffer_reg;
        logic [7:0] byte_shift_register;
        logic buffer_full_flag;
        logic write_collision_flag;
        logic serial_port_irq_flag;
        logic ack_status_flag;
        logic start_request_bit;
        logic restart_request_bit;
        logic stop_request_bit;
        logic [7:0] baud_div;
        logic [7:0] baud_cnt;
        logic [3:0] bit_cnt;
        i2mt_pkg::i2mt_state_type state;
        logic scl_low;
        logic sda_low;
        logic [2:0] irq_status;
        logic [2:0] irq_enable;
        logic irq;
    } i2mt_regs_type;

    i2mt_regs_type r_q; // Registered state
    i2mt_regs_type r_d; // Next state

    // Register read mux, unmapped reads give zero
    function automatic logic [31:0] read_mux(input i2mt_regs_type r, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            i2mt_pkg::OFF_TX_BUFFER: v[7:0] = r.tx_buffer_reg;
            i2mt_pkg::OFF_STATUS: begin
                v[i2mt_pkg::BIT_BUFFER_FULL] = r.buffer_full_flag;
                v[i2mt_pkg::BIT_WRITE_COLLISION] = r.write_collision_flag;
                v[i2mt_pkg::BIT_SERIAL_IRQ] = r.serial_port_irq_flag;
            end
            i2mt_pkg::OFF_CONTROL_TWO: begin
                v[i2mt_pkg::BIT_START_REQ] = r.start_request_bit;
                v[i2mt_pkg::BIT_RESTART_REQ] = r.restart_request_bit;
                v[i2mt_pkg::BIT_STOP_REQ] = r.stop_request_bit;
                v[i2mt_pkg::BIT_ACK_STATUS] = r.ack_status_flag;
            end
            i2mt_pkg::OFF_BAUD: v[7:0] = r.baud_div;
            i2mt_pkg::OFF_IRQ_STATUS: v[2:0] = r.irq_status;
            i2mt_pkg::OFF_IRQ_ENABLE: v[2:0] = r.irq_enable;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Offset decode shared by both bus channels
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == i2mt_pkg::OFF_TX_BUFFER) || (a == i2mt_pkg::OFF_STATUS) ||
               (a == i2mt_pkg::OFF_CONTROL_TWO) || (a == i2mt_pkg::OFF_BAUD) ||
               (a == i2mt_pkg::OFF_IRQ_STATUS) || (a == i2mt_pkg::OFF_IRQ_ENABLE) ||
               (a == i2mt_pkg::OFF_IRQ_CLEAR);
    endfunction

    // Next-state logic for bus slave, registers and bit sequencer
    always_comb begin
        logic do_write;
        logic tick;
        logic busy;
        logic byte_done;
        logic cond_done;
        logic collide;
        logic [2:0] irq_set;
        r_d = r_q;
        do_write = 1'b0;
        tick = 1'b0;
        byte_done = 1'b0;
        cond_done = 1'b0;
        collide = 1'b0;
        irq_set = 3'h0;
        busy = (r_q.state != i2mt_pkg::ST_IDLE);

        // Write channels may arrive in either order; each is latched once taken
        if (s_axi_awvalid && !r_q.aw_seen) begin
            r_d.aw_seen = 1'b1;
            r_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r_q.w_seen) begin
            r_d.w_seen = 1'b1;
            r_d.w_data = s_axi_wdata;
            r_d.w_strb = s_axi_wstrb;
        end
        // Act once both halves are held and the previous answer is gone
        if (r_q.aw_seen && r_q.w_seen && !r_q.bvalid) begin
            do_write = 1'b1;
            r_d.aw_seen = 1'b0;
            r_d.w_seen = 1'b0;
            r_d.bvalid = 1'b1;
            r_d.bresp = is_mapped(r_q.aw_addr) ? i2mt_pkg::RESP_OKAY : i2mt_pkg::RESP_SLVERR;
        end
        if (r_q.bvalid && s_axi_bready) begin
            r_d.bvalid = 1'b0;
        end

        // Read: address taken when no answer is pending, data one cycle later
        if (s_axi_arvalid && !r_q.rvalid) begin
            r_d.rvalid = 1'b1;
            r_d.rdata = read_mux(r_q, s_axi_araddr);
            r_d.rresp = is_mapped(s_axi_araddr) ? i2mt_pkg::RESP_OKAY : i2mt_pkg::RESP_SLVERR;
        end else if (r_q.rvalid && s_axi_rready) begin
            r_d.rvalid = 1'b0;
        end

        // Register writes, only low byte lane carries fields
        if (do_write && r_q.w_strb[0]) begin
            unique case (r_q.aw_addr)
                i2mt_pkg::OFF_TX_BUFFER: begin
                    if (busy) begin
                        collide = 1'b1;
                    end else begin
                        r_d.tx_buffer_reg = r_q.w_data[7:0];
                        r_d.byte_shift_register = r_q.w_data[7:0];
                        r_d.sda_low = !r_q.w_data[7];
                        r_d.buffer_full_flag = 1'b1;
                        r_d.bit_cnt = 4'h0;
                        r_d.baud_cnt = 8'h00;
                        r_d.state = i2mt_pkg::ST_BIT_LOW;
                    end
                end
                i2mt_pkg::OFF_STATUS: begin
                    // Software clears the collision and serial interrupt flags by writing zero
                    if (!r_q.w_data[i2mt_pkg::BIT_WRITE_COLLISION]) begin
                        r_d.write_collision_flag = 1'b0;
                    end
                    if (!r_q.w_data[i2mt_pkg::BIT_SERIAL_IRQ]) begin
                        r_d.serial_port_irq_flag = 1'b0;
                    end
                end
                i2mt_pkg::OFF_CONTROL_TWO: begin
                    // Requests are ignored while a byte or condition runs
                    if (!busy) begin
                        r_d.baud_cnt = 8'h00;
                        if (r_q.w_data[i2mt_pkg::BIT_START_REQ]) begin
                            r_d.start_request_bit = 1'b1;
                            r_d.state = i2mt_pkg::ST_START_A;
                        end else if (r_q.w_data[i2mt_pkg::BIT_RESTART_REQ]) begin
                            r_d.restart_request_bit = 1'b1;
                            r_d.state = i2mt_pkg::ST_RESTART_A;
                        end else if (r_q.w_data[i2mt_pkg::BIT_STOP_REQ]) begin
                            r_d.stop_request_bit = 1'b1;
                            r_d.state = i2mt_pkg::ST_STOP_A;
                        end
                    end
                end
                i2mt_pkg::OFF_BAUD: r_d.baud_div = r_q.w_data[7:0];
                i2mt_pkg::OFF_IRQ_ENABLE: r_d.irq_enable = r_q.w_data[2:0];
                i2mt_pkg::OFF_IRQ_CLEAR: r_d.irq_status = r_q.irq_status & ~r_q.w_data[2:0];
                default: ;
            endcase
        end

        // Baud generator runs only while a sequence is active; halted otherwise
        if (busy) begin
            if (r_q.baud_cnt == r_q.baud_div) begin
                r_d.baud_cnt = 8'h00;
                tick = 1'b1;
            end else begin
                r_d.baud_cnt = r_q.baud_cnt + 8'h01;
            end
        end

        // Bit sequencer, one phase per baud tick
        if (tick) begin
            unique case (r_q.state)
                i2mt_pkg::ST_IDLE: ;
                i2mt_pkg::ST_START_A: begin
                    r_d.scl_low = 1'b0;
                    r_d.sda_low = 1'b1; // Data falls while clock high
                    r_d.state = i2mt_pkg::ST_START_B;
                end
                i2mt_pkg::ST_START_B: begin
                    r_d.scl_low = 1'b1;
                    cond_done = 1'b1;
                    r_d.start_request_bit = 1'b0;
                    r_d.restart_request_bit = 1'b0;
                    r_d.state = i2mt_pkg::ST_IDLE;
                end
                i2mt_pkg::ST_RESTART_A: begin
                    r_d.sda_low = 1'b0;
                    r_d.scl_low = 1'b0;
                    r_d.state = i2mt_pkg::ST_RESTART_B;
                end
                i2mt_pkg::ST_RESTART_B: begin
                    r_d.sda_low = 1'b1;
                    r_d.state = i2mt_pkg::ST_START_B;
                end
                i2mt_pkg::ST_BIT_LOW: begin
                    // Data already stands from the falling edge, so only the clock rises
                    r_d.scl_low = 1'b0;
                    r_d.state = i2mt_pkg::ST_BIT_HIGH;
                end
                i2mt_pkg::ST_BIT_HIGH: begin
                    // Falling clock edge closes the bit
                    r_d.scl_low = 1'b1;
                    r_d.byte_shift_register = {r_q.byte_shift_register[6:0], 1'b0};
                    r_d.bit_cnt = r_q.bit_cnt + 4'h1;
                    if (r_q.bit_cnt == i2mt_pkg::BITS_PER_BYTE - 4'h1) begin
                        r_d.sda_low = 1'b0;
                        r_d.state = i2mt_pkg::ST_ACK_LOW;
                    end else begin
                        r_d.sda_low = !r_q.byte_shift_register[6];
                        r_d.state = i2mt_pkg::ST_BIT_LOW;
                    end
                end
                i2mt_pkg::ST_ACK_LOW: begin
                    r_d.scl_low = 1'b0;
                    r_d.state = i2mt_pkg::ST_ACK_HIGH;
                end
                i2mt_pkg::ST_ACK_HIGH: begin
                    // Ninth falling edge: sample, flag, then park
                    r_d.scl_low = 1'b1;
                    r_d.ack_status_flag = sda_i;
                    r_d.buffer_full_flag = 1'b0;
                    byte_done = 1'b1;
                    r_d.state = i2mt_pkg::ST_IDLE;
                end
                i2mt_pkg::ST_STOP_A: begin
                    r_d.sda_low = 1'b1;
                    r_d.scl_low = 1'b1;
                    r_d.state = i2mt_pkg::ST_STOP_B;
                end
                i2mt_pkg::ST_STOP_B: begin
                    r_d.scl_low = 1'b0;
                    r_d.state = i2mt_pkg::ST_STOP_C;
                end
                i2mt_pkg::ST_STOP_C: begin
                    r_d.sda_low = 1'b0; // Data rises while clock high
                    cond_done = 1'b1;
                    r_d.stop_request_bit = 1'b0;
                    r_d.state = i2mt_pkg::ST_IDLE;
                end
                default: r_d.state = i2mt_pkg::ST_IDLE;
            endcase
        end

        // Hardware sets win over software clears in the same cycle
        if (collide) begin
            r_d.write_collision_flag = 1'b1;
        end
        if (byte_done || cond_done) begin
            r_d.serial_port_irq_flag = 1'b1;
        end
        irq_set[i2mt_pkg::IRQ_BYTE_DONE] = byte_done;
        irq_set[i2mt_pkg::IRQ_COND_DONE] = cond_done;
        irq_set[i2mt_pkg::IRQ_COLLISION] = collide;
        r_d.irq_status = r_d.irq_status | irq_set;
        r_d.irq = |(r_d.irq_status & r_d.irq_enable);
    end

    // Single register stage, synchronous active-low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_q <= '0;
            r_q.state <= i2mt_pkg::ST_IDLE;
            r_q.baud_div <= i2mt_pkg::BAUD_RESET;
            r_q.ack_status_flag <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = !r_q.aw_seen;
    assign s_axi_wready = !r_q.w_seen;
    assign s_axi_bvalid = r_q.bvalid;
    assign s_axi_bresp = r_q.bresp;
    assign s_axi_arready = !r_q.rvalid;
    assign s_axi_rvalid = r_q.rvalid;
    assign s_axi_rdata = r_q.rdata;
    assign s_axi_rresp = r_q.rresp;
    assign scl_o = 1'b0;
    assign scl_oe = r_q.scl_low;
    assign sda_o = 1'b0;
    assign sda_oe = r_q.sda_low;
    assign irq = r_q.irq;

endmodule

// ==== tb/i2mt_assertions.sv ====
// Checker for the two-wire transmitter: register bus handshakes and pin timing.
// Sees only the top module's ports; it is bound at the foot of this file.
module i2mt_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pin enables and interrupt
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both write channels taken at one edge with no response pending
    logic wr_take;
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;

    AST_RESET_QUIET:
        assert property ($rose(aresetn) |-> !scl_oe && !sda_oe && !irq && !s_axi_bvalid)
        else $error("outputs not quiet after reset");
    AST_B_STANDS:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_STANDS:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_AR_BLOCKED:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    AST_B_ANSWER:
        assert property (wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_R_ANSWER:
        assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data late");
    AST_WR_UNMAPPED:
        assert property (wr_take && s_axi_awaddr == 8'h1C |->
            ##[1:2] (s_axi_bvalid && s_axi_bresp == i2mt_pkg::RESP_SLVERR))
        else $error("unmapped write not refused");
    AST_SDA_SCL_LOW:
        assert property ($fell(scl_oe) |-> !$rose(sda_oe))
        else $error("data line changed while clock rising");
    // Main scenarios
    cover property ($rose(irq));
    cover property ($rose(sda_oe));
    cover property (wr_take && s_axi_awaddr == 8'h1C);
endmodule

bind i2mt_top i2mt_checker chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .scl_oe(scl_oe), .sda_oe(sda_oe), .irq(irq)
);

// ==== tb/i2mt_slave_model.sv ====
// Behavioural slave on the two-wire bus: captures a byte and answers the ack.
// Assumes wire levels resolved by the bench with pull-ups on both lines.
module i2mt_slave_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Resolved bus lines
    input wire logic scl,
    input wire logic sda,
    // Ack low when set, else leave the line to its pull-up
    input wire logic ack_en,
    // Outputs
    output logic sda_pull,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    // Edge detection runs off the system clock; lines are already synchronous
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
            sda_pull <= 1'h0;
            bit_cnt <= 4'h0;
            rx_byte <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            // Start or restart: data falls while clock high
            if (scl && scl_q && sda_q && !sda) begin
                bit_cnt <= 4'h0;
            end else if (scl && !scl_q && bit_cnt < 4'h9) begin
                // Rising clock samples, most significant bit arrives first
                if (bit_cnt < 4'h8) begin
                    rx_byte <= {rx_byte[6:0], sda};
                end
                bit_cnt <= bit_cnt + 4'h1;
            end else if (!scl && scl_q && bit_cnt == 4'h9) begin
                // Ninth clock over: ready for a following byte
                bit_cnt <= 4'h0;
            end
            // Drive the ack only through the ninth clock
            if (!scl && scl_q) begin
                sda_pull <= (bit_cnt == 4'h8) && ack_en;
            end
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the two-wire transmitter with a slave model.
// Reads and write responses are checked by a monitor against a queue.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [31:0] v; logic [31:0] m; logic [1:0] r;} i2mt_exp_type;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rx_byte, d;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, irq, sda_pull, ack_en;
    i2mt_exp_type expq[$];
    i2mt_exp_type e;
    int mismatches = 0;
    int n_checks = 0;
    // Open-drain wires with pull-ups
    assign scl_i = !scl_oe;
    assign sda_i = !(sda_oe || sda_pull);

    i2mt_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    i2mt_slave_model slv (.aclk(aclk), .aresetn(aresetn), .scl(scl_i), .sda(sda_i),
        .ack_en(ack_en), .sda_pull(sda_pull), .rx_byte(rx_byte));

    // 250 MHz clock
    initial begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end

    task automatic chk_bus(input i2mt_exp_type x, input logic [31:0] dv, input logic [1:0] r);
        n_checks++;
        if ((dv & x.m) !== (x.v & x.m) || r !== x.r) begin
            mismatches++;
            $display("[FAIL] reg %h expected %h/%h seen %h/%h", x.a, x.v, x.r, dv, r);
        end
    endtask

    task automatic chk_bit(input string nm, input logic [7:0] ex, input logic [7:0] got);
        n_checks++;
        if (got !== ex) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // Write with expected response noted first
    task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] r);
        expq.push_back('{a, dv, 32'h0, r});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= dv;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
                      input logic [1:0] r);
        expq.push_back('{a, v, m, r});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask

    // Bounded wait for the interrupt line
    task automatic wait_irq();
        int n = 0;
        while (irq !== 1'h1 && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        chk_bit("irq", 8'h1, irq);
    endtask

    // Monitor: each bus answer takes the oldest note
    always @(posedge aclk) begin
        if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
            e = expq.pop_front();
            chk_bus(e, s_axi_rdata, s_axi_rvalid ? s_axi_rresp : s_axi_bresp);
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watchdog: the whole run needs well under this span
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        test_done();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        ack_en = 1'h1;
        void'($urandom(32'h305853AE));
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        rd(i2mt_pkg::OFF_STATUS, 32'h0, 32'hFF, i2mt_pkg::RESP_OKAY);
        rd(i2mt_pkg::OFF_CONTROL_TWO, 32'h40, 32'hFF, i2mt_pkg::RESP_OKAY);
        rd(i2mt_pkg::OFF_BAUD, 32'h9F, 32'hFF, i2mt_pkg::RESP_OKAY);
        rd(8'h1C, 32'h0, 32'hFFFFFFFF, i2mt_pkg::RESP_SLVERR);
        wr(8'h1C, 32'h1, i2mt_pkg::RESP_SLVERR);
        $display("test registers done");
        // Short bus phases; collision stays out of the interrupt line
        wr(i2mt_pkg::OFF_BAUD, 32'h3, i2mt_pkg::RESP_OKAY);
        wr(i2mt_pkg::OFF_IRQ_ENABLE, 32'h3, i2mt_pkg::RESP_OKAY);
        wr(i2mt_pkg::OFF_CONTROL_TWO, 32'h1, i2mt_pkg::RESP_OKAY);
        wait_irq();
        rd(i2mt_pkg::OFF_IRQ_STATUS, 32'h2, 32'h7, i2mt_pkg::RESP_OKAY);
        wr(i2mt_pkg::OFF_IRQ_CLEAR, 32'h7, i2mt_pkg::RESP_OKAY);
        wr(i2mt_pkg::OFF_STATUS, 32'h0, i2mt_pkg::RESP_OKAY);
        chk_bit("irq", 8'h0, irq);
        $display("test start done");
        // Acked byte, then a refused one
        for (int k = 0; k < 2; k++) begin
            ack_en <= (k == 0);
            d = 8'($urandom);
            wr(i2mt_pkg::OFF_TX_BUFFER, {24'h0, d}, i2mt_pkg::RESP_OKAY);
            rd(i2mt_pkg::OFF_STATUS, 32'h1, 32'h1, i2mt_pkg::RESP_OKAY);
            wr(i2mt_pkg::OFF_TX_BUFFER, {24'h0, ~d}, i2mt_pkg::RESP_OKAY);
            rd(i2mt_pkg::OFF_TX_BUFFER, {24'h0, d}, 32'hFF, i2mt_pkg::RESP_OKAY);
            wait_irq();
            chk_bit("scl_oe", 8'h1, scl_oe);
            chk_bit("sda_oe", 8'h0, sda_oe);
            chk_bit("pin_out", 8'h0, {6'h0, scl_o, sda_o});
            chk_bit("rx_byte", d, rx_byte);
            rd(i2mt_pkg::OFF_CONTROL_TWO, 32'h40 * k, 32'h47, i2mt_pkg::RESP_OKAY);
            rd(i2mt_pkg::OFF_STATUS, 32'h6, 32'h7, i2mt_pkg::RESP_OKAY);
            rd(i2mt_pkg::OFF_IRQ_STATUS, 32'h5, 32'h7, i2mt_pkg::RESP_OKAY);
            wr(i2mt_pkg::OFF_STATUS, 32'h0, i2mt_pkg::RESP_OKAY);
            rd(i2mt_pkg::OFF_STATUS, 32'h0, 32'h7, i2mt_pkg::RESP_OKAY);
            wr(i2mt_pkg::OFF_IRQ_CLEAR, 32'h7, i2mt_pkg::RESP_OKAY);
            $display("test byte %0d done", k);
        end
        wr(i2mt_pkg::OFF_CONTROL_TWO, 32'h4, i2mt_pkg::RESP_OKAY);
        wait_irq();
        rd(i2mt_pkg::OFF_IRQ_STATUS, 32'h2, 32'h7, i2mt_pkg::RESP_OKAY);
        rd(i2mt_pkg::OFF_CONTROL_TWO, 32'h0, 32'h7, i2mt_pkg::RESP_OKAY);
        $display("test stop done");
        wr(i2mt_pkg::OFF_IRQ_CLEAR, 32'h7, i2mt_pkg::RESP_OKAY);
        wr(i2mt_pkg::OFF_CONTROL_TWO, 32'h2, i2mt_pkg::RESP_OKAY);
        wait_irq();
        rd(i2mt_pkg::OFF_CONTROL_TWO, 32'h0, 32'h7, i2mt_pkg::RESP_OKAY);
        $display("test restart done");
        test_done();
    end
endmodule
